// file: uart_consts.vh
// register map, field positions and reset values of the serial transceiver
`ifndef UART_CONSTS_VH
`define UART_CONSTS_VH
`define OFF_DATA 12'h000
`define OFF_RSR 12'h004
`define OFF_FLAG 12'h018
`define OFF_IDIV 12'h024
`define OFF_FDIV 12'h028
`define OFF_LCR 12'h02C
`define OFF_CTL 12'h030
`define OFF_FLS 12'h034
`define OFF_MASK 12'h038
`define OFF_RAW 12'h03C
`define OFF_MIS 12'h040
`define OFF_ICR 12'h044
`define CTL_RESET 10'h300
`define FLS_RESET 6'h12
`define LCR_BRK 0
`define LCR_PEN 1
`define LCR_EPS 2
`define LCR_STP2 3
`define LCR_FEN 4
`define LCR_SPS 7
`define CTL_EN 0
`define CTL_LBE 7
`define CTL_TXE 8
`define CTL_RXE 9
`define INT_RX 4
`define INT_TX 5
`define INT_RT 6
`define INT_FE 7
`define INT_PE 8
`define INT_BE 9
`define INT_OE 10
`define RT_TICKS 9'h1FF
`define RESP_OK 2'h0
`define RESP_ERR 2'h2
`endif

// file: uart_core.v
// serial transceiver with fifos, fractional baud generator and axi4-lite regs
`timescale 1ns/1ps
`include "uart_consts.vh"
module uart_core #(
  parameter DEPTH = 16,
  parameter AW = 12
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // axi4-lite write
  input wire [AW-1:0] awaddr,
  input wire awvalid,
  output reg awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output reg wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  // axi4-lite read
  input wire [AW-1:0] araddr,
  input wire arvalid,
  output reg arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  // serial lines and interrupt
  input wire serial_in_line,
  output reg serial_out_line,
  output reg irq
);
  localparam T_IDLE = 3'h0, T_START = 3'h1, T_DATA = 3'h2, T_PAR = 3'h3,
    T_STOP = 3'h4;

  // byte-lane merge of a write into a register image
  function [31:0] wmerge(input [31:0] o, input [31:0] n, input [3:0] s);
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1)
        wmerge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction
  // parity bit for the given data, length and mode
  function par_bit(input [7:0] d, input [1:0] wl, input eps, input sps);
    reg [7:0] m;
    begin
      m = d & (8'hFF >> (2'h3 - wl));
      par_bit = sps ? ~eps : (eps ? ^m : ~^m);
    end
  endfunction
  // trigger level in entries from a select code
  function [4:0] level(input [2:0] sel, input fifo_enable_bit);
    begin
      if (!fifo_enable_bit) level = 5'h01;
      else case (sel)
        3'h0: level = 5'h02;
        3'h1: level = 5'h04;
        3'h3: level = 5'h0C;
        3'h4: level = 5'h0E;
        default: level = 5'h08;
      endcase
    end
  endfunction

  reg [15:0] idiv_q;
  reg [5:0] fdiv_q;
  reg [7:0] lcr_q;
  reg [29:0] act_q;
  reg [9:0] ctl_q;
  reg [5:0] fls_q;
  reg [10:0] mask_q, raw_q;
  reg [3:0] rsr_q;
  reg aw_have_q, w_have_q;
  reg [AW-1:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [7:0] tx_mem [0:DEPTH-1];
  reg [11:0] rx_mem [0:DEPTH-1];
  reg [3:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  reg [4:0] tx_cnt_q, rx_cnt_q;
  reg [15:0] bcnt_q;
  reg [5:0] acc_q;
  reg extra_q;
  reg [2:0] ts_q, rs_q;
  reg [3:0] tsub_q, rsub_q;
  reg [2:0] tbit_q, rbit_q;
  reg [7:0] tsh_q, rsh_q;
  reg tpar_q, rprev_q, perr_q, zero_q, ovr_q, rx_hit_q, tx_hit_q;
  reg rx_s1_q, rx_s2_q;
  reg [8:0] rt_q;

  // active framing from the latched 30-bit image
  wire [15:0] div_i = act_q[29:14];
  wire [5:0] div_f = act_q[13:8];
  wire [7:0] lcr = act_q[7:0];
  wire fifo_enable_bit = lcr[`LCR_FEN];
  wire [1:0] wlen = lcr[6:5];
  wire [4:0] cap = fifo_enable_bit ? DEPTH[4:0] : 5'h01;
  wire tx_full = tx_cnt_q >= cap;
  wire rx_full = rx_cnt_q >= cap;
  wire tx_empty = tx_cnt_q == 5'h00;
  wire rx_empty = rx_cnt_q == 5'h00;
  wire [2:0] nbits = {1'b0, wlen} + 3'h4; // last data bit index
  wire en = ctl_q[`CTL_EN];

  // bus handshakes
  wire do_wr = aw_have_q & w_have_q & ~bvalid;
  wire do_rd = arvalid & arready;
  wire [11:0] wa = {awaddr_q[11:2], 2'b00};
  wire [11:0] ra = {araddr[11:2], 2'b00};
  wire dr_wr = do_wr && wa == `OFF_DATA && wstrb_q[0];
  wire dr_rd = do_rd && ra == `OFF_DATA;
  wire tx_push = dr_wr && !tx_full;
  wire rx_pop = dr_rd && !rx_empty;

  // oversample tick: period of div_i plus a carried fractional cycle
  wire tick = div_i != 16'h0000 &&
    ({1'b0, bcnt_q} + 17'h00001 >= {1'b0, div_i} + {16'h0000, extra_q});
  wire [6:0] acc_sum = {1'b0, acc_q} + {1'b0, div_f};
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bcnt_q <= 16'h0000;
      acc_q <= 6'h00;
      extra_q <= 1'b0;
    end else if (tick) begin
      bcnt_q <= 16'h0000;
      acc_q <= acc_sum[5:0];
      extra_q <= acc_sum[6];
    end else begin
      bcnt_q <= bcnt_q + 16'h0001;
    end
  end

  // transmitter: start pops the fifo, then sixteen ticks per bit
  wire tx_pop = ts_q == T_IDLE && !tx_empty && en && ctl_q[`CTL_TXE];
  wire tend = tick && tsub_q == 4'hF;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ts_q <= T_IDLE;
      tsub_q <= 4'h0;
      tbit_q <= 3'h0;
      tsh_q <= 8'h00;
      tpar_q <= 1'b0;
    end else begin
      if (tick) tsub_q <= tsub_q + 4'h1;
      case (ts_q)
        T_IDLE: if (tx_pop) begin
          ts_q <= T_START;
          tsub_q <= 4'h0;
          tsh_q <= tx_mem[tx_rp_q];
          tpar_q <= par_bit(tx_mem[tx_rp_q], wlen, lcr[`LCR_EPS],
            lcr[`LCR_SPS]);
        end
        T_START: if (tend) begin
          ts_q <= T_DATA;
          tbit_q <= 3'h0;
        end
        T_DATA: if (tend) begin
          tsh_q <= {1'b0, tsh_q[7:1]};
          tbit_q <= tbit_q + 3'h1;
          if (tbit_q == nbits) begin
            ts_q <= lcr[`LCR_PEN] ? T_PAR : T_STOP;
            tbit_q <= 3'h0;
          end
        end
        T_PAR: if (tend) ts_q <= T_STOP;
        T_STOP: if (tend) begin
          tbit_q <= tbit_q + 3'h1;
          if (tbit_q[0] || !lcr[`LCR_STP2]) ts_q <= T_IDLE;
        end
        default: ts_q <= T_IDLE;
      endcase
    end
  end

  // line driver, forced low while break is requested
  always @(posedge sys_clk or posedge rst) begin
    if (rst) serial_out_line <= 1'b1;
    else case (ts_q)
      T_START: serial_out_line <= 1'b0;
      T_DATA: serial_out_line <= tsh_q[0] & ~lcr[`LCR_BRK];
      T_PAR: serial_out_line <= tpar_q & ~lcr[`LCR_BRK];
      default: serial_out_line <= ~lcr[`LCR_BRK];
    endcase
  end

  // receive input synchroniser and loopback select
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= serial_in_line;
      rx_s2_q <= rx_s1_q;
    end
  end
  wire rx_in = ctl_q[`CTL_LBE] ? serial_out_line : rx_s2_q;

  // receiver; an accepted character runs to its stop sample
  wire rend = tick && rsub_q == 4'hF;
  wire [7:0] rdat = rsh_q >> (3'h7 - nbits);
  wire rx_done = rs_q == T_STOP && rend;
  wire rx_push = rx_done && !rx_full;
  wire brk_in = zero_q & ~rx_in;
  wire [11:0] rx_ent = {ovr_q, brk_in, perr_q, ~rx_in, rdat};
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rs_q <= T_IDLE;
      rsub_q <= 4'h0;
      rbit_q <= 3'h0;
      rsh_q <= 8'h00;
      rprev_q <= 1'b1;
      perr_q <= 1'b0;
      zero_q <= 1'b1;
    end else begin
      if (tick) begin
        rsub_q <= rsub_q + 4'h1;
        rprev_q <= rx_in;
      end
      case (rs_q)
        T_IDLE: if (tick && rprev_q && !rx_in && en &&
            ctl_q[`CTL_RXE]) begin
          rs_q <= T_START;
          rsub_q <= 4'h0;
        end
        T_START: if (tick && rsub_q == 4'h7) begin
          rs_q <= rx_in ? T_IDLE : T_DATA;
          rsub_q <= 4'h0;
          rbit_q <= 3'h0;
          perr_q <= 1'b0;
          zero_q <= 1'b1;
        end
        T_DATA: if (rend) begin
          rsh_q <= {rx_in, rsh_q[7:1]};
          zero_q <= zero_q & ~rx_in;
          rbit_q <= rbit_q + 3'h1;
          if (rbit_q == nbits) rs_q <= lcr[`LCR_PEN] ? T_PAR : T_STOP;
        end
        T_PAR: if (rend) begin
          perr_q <= rx_in != par_bit(rdat, wlen, lcr[`LCR_EPS],
            lcr[`LCR_SPS]);
          zero_q <= zero_q & ~rx_in;
          rs_q <= T_STOP;
        end
        T_STOP: if (rend) rs_q <= T_IDLE;
        default: rs_q <= T_IDLE;
      endcase
    end
  end

  // fifo storage and pointers
  always @(posedge sys_clk) begin
    if (tx_push) tx_mem[tx_wp_q] <= wdata_q[7:0];
    if (rx_push) rx_mem[rx_wp_q] <= rx_ent;
  end
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_wp_q <= 4'h0;
      tx_rp_q <= 4'h0;
      rx_wp_q <= 4'h0;
      rx_rp_q <= 4'h0;
      tx_cnt_q <= 5'h00;
      rx_cnt_q <= 5'h00;
    end else begin
      if (tx_push) tx_wp_q <= tx_wp_q + 4'h1;
      if (tx_pop) tx_rp_q <= tx_rp_q + 4'h1;
      if (rx_push) rx_wp_q <= rx_wp_q + 4'h1;
      if (rx_pop) rx_rp_q <= rx_rp_q + 4'h1;
      tx_cnt_q <= tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
      rx_cnt_q <= rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop};
    end
  end

  // receive timeout: rx fifo holds data and line idle for 32 bits
  always @(posedge sys_clk or posedge rst) begin
    if (rst) rt_q <= 9'h000;
    else if (rx_empty || rs_q != T_IDLE || rx_pop) rt_q <= 9'h000;
    else if (tick && rt_q != `RT_TICKS) rt_q <= rt_q + 9'h001;
  end

  // raw events: hardware set wins over software clear
  wire rx_hit = rx_cnt_q >= level(fls_q[5:3], fifo_enable_bit);
  wire tx_hit = tx_cnt_q <= (fifo_enable_bit ? level(fls_q[2:0], fifo_enable_bit) : 5'h00);
  wire icr_wr = do_wr && wa == `OFF_ICR;
  wire [31:0] clr_w = icr_wr ? wmerge(32'h0, wdata_q, wstrb_q) : 32'h0;
  wire [10:0] clr = clr_w[10:0];
  wire [10:0] set;
  assign set[3:0] = 4'h0;
  assign set[`INT_RX] = rx_hit & ~rx_hit_q;
  assign set[`INT_TX] = tx_hit & ~tx_hit_q;
  assign set[`INT_RT] = tick && rt_q == `RT_TICKS - 9'h001;
  assign set[`INT_FE] = rx_done & ~rx_in;
  assign set[`INT_PE] = rx_done & perr_q;
  assign set[`INT_BE] = rx_done & brk_in;
  assign set[`INT_OE] = rx_done & rx_full;
  wire [10:0] lvl_clr = {4'h0, rx_empty, ~tx_hit, ~rx_hit, 4'h0};
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      raw_q <= 11'h000;
      rx_hit_q <= 1'b0;
      tx_hit_q <= 1'b0;
      irq <= 1'b0;
    end else begin
      rx_hit_q <= rx_hit;
      tx_hit_q <= tx_hit;
      raw_q <= (raw_q & ~clr & ~lvl_clr) | set;
      irq <= |(raw_q & mask_q);
    end
  end

  // receive status: overrun sticky, errors of last read entry
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rsr_q <= 4'h0;
      ovr_q <= 1'b0;
    end else begin
      if (rx_push) ovr_q <= 1'b0;
      if (rx_pop) rsr_q[2:0] <= rx_mem[rx_rp_q][10:8];
      if (do_wr && wa == `OFF_RSR) rsr_q <= 4'h0;
      if (rx_done && rx_full) begin
        ovr_q <= 1'b1;
        rsr_q[3] <= 1'b1;
      end
    end
  end

  // axi4-lite write side: address and data taken in either order
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= {AW{1'b0}};
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `RESP_OK;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_have_q <= 1'b1;
        awaddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_have_q <= 1'b1;
        wdata_q <= wdata;
        wstrb_q <= wstrb;
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid <= 1'b1;
        case (wa)
          `OFF_DATA, `OFF_RSR, `OFF_IDIV, `OFF_FDIV, `OFF_LCR, `OFF_CTL,
          `OFF_FLS, `OFF_MASK, `OFF_ICR: bresp <= `RESP_OK;
          default: bresp <= `RESP_ERR;
        endcase
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // configuration registers; the line write latches the whole image
  wire [31:0] wm_i = wmerge({16'h0, idiv_q}, wdata_q, wstrb_q);
  wire [31:0] wm_f = wmerge({26'h0, fdiv_q}, wdata_q, wstrb_q);
  wire [31:0] wm_l = wmerge({24'h0, lcr_q}, wdata_q, wstrb_q);
  wire [31:0] wm_c = wmerge({22'h0, ctl_q}, wdata_q, wstrb_q);
  wire [31:0] wm_s = wmerge({26'h0, fls_q}, wdata_q, wstrb_q);
  wire [31:0] wm_m = wmerge({21'h0, mask_q}, wdata_q, wstrb_q);
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idiv_q <= 16'h0000;
      fdiv_q <= 6'h00;
      lcr_q <= 8'h00;
      act_q <= 30'h00000000;
      ctl_q <= `CTL_RESET;
      fls_q <= `FLS_RESET;
      mask_q <= 11'h000;
    end else if (do_wr) begin
      case (wa)
        `OFF_IDIV: idiv_q <= wm_i[15:0];
        `OFF_FDIV: fdiv_q <= wm_f[5:0];
        `OFF_LCR: begin
          lcr_q <= wm_l[7:0];
          act_q <= {idiv_q, fdiv_q, wm_l[7:0]};
        end
        `OFF_CTL: ctl_q <= wm_c[9:0];
        `OFF_FLS: fls_q <= wm_s[5:0];
        `OFF_MASK: mask_q <= wm_m[10:0];
        default: ctl_q <= ctl_q;
      endcase
    end
  end

  // axi4-lite read side: one-cycle registered answer
  wire busy = !tx_empty || ts_q != T_IDLE;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `RESP_OK;
    end else begin
      if (do_rd) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rresp <= `RESP_OK;
        case (ra)
          `OFF_DATA: rdata <= rx_empty ? 32'h0 : {20'h0, rx_mem[rx_rp_q]};
          `OFF_RSR: rdata <= {28'h0, rsr_q};
          `OFF_FLAG: rdata <= {24'h0, tx_empty, rx_full, tx_full,
            rx_empty, busy, 3'h0};
          `OFF_IDIV: rdata <= {16'h0, idiv_q};
          `OFF_FDIV: rdata <= {26'h0, fdiv_q};
          `OFF_LCR: rdata <= {24'h0, lcr_q};
          `OFF_CTL: rdata <= {22'h0, ctl_q};
          `OFF_FLS: rdata <= {26'h0, fls_q};
          `OFF_MASK: rdata <= {21'h0, mask_q};
          `OFF_RAW: rdata <= {21'h0, raw_q};
          `OFF_MIS: rdata <= {21'h0, raw_q & mask_q};
          `OFF_ICR: rdata <= 32'h0;
          default: begin
            rdata <= 32'h0;
            rresp <= `RESP_ERR;
          end
        endcase
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule

// file: uart_core_asserts.sv
// bus handshake and serial line checks on the transceiver ports
`timescale 1ns/1ps
module uart_core_asserts #(
  parameter DEPTH = 16,
  parameter AW = 12
) (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // bus handshakes
  input wire awvalid,
  input wire awready,
  input wire wvalid,
  input wire wready,
  input wire [1:0] bresp,
  input wire bvalid,
  input wire bready,
  input wire arvalid,
  input wire arready,
  input wire [31:0] rdata,
  input wire rvalid,
  input wire rready,
  // serial output
  input wire serial_out_line
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // write answer two edges after a joint address and data handshake
  property p_wr_answer;
    awvalid && awready && wvalid && wready |-> ##2 bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("late write");
  property p_rd_answer;
    arvalid && arready |=> rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("late read");
  property p_b_hold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("b dropped");
  property p_r_hold;
    rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("r dropped");
  property p_r_block;
    rvalid |-> !arready;
  endproperty
  a_r_block: assert property (p_r_block) else $error("ar open");
  property p_b_block;
    bvalid |-> !awready && !wready;
  endproperty
  a_b_block: assert property (p_b_block) else $error("aw open");
  property p_b_done;
    bvalid && bready |=> !bvalid && awready && wready;
  endproperty
  a_b_done: assert property (p_b_done) else $error("no reopen");
  // a low level never lasts less than eight cycles, half a bit at a divisor of one
  property p_bit_len;
    $fell(serial_out_line) |-> !serial_out_line [*8];
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("short bit");
endmodule
bind uart_core uart_core_asserts #(.DEPTH(DEPTH), .AW(AW)) chk_u (
  .sys_clk(sys_clk), .rst(rst), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .serial_out_line(serial_out_line));

// file: serial_peer.sv
// remote serial device: sends frames and collects received ones
`timescale 1ns/1ps
module serial_peer (
  // clock and lines
  input wire sys_clk,
  input wire line_from_dut,
  output logic line_to_dut
);
  int len = 10;
  logic [11:0] got_q[$];
  logic [11:0] sh;
  initial line_to_dut = 1'b1;
  // sample each bit at its centre, sixteen cycles apart
  always begin
    @(negedge line_from_dut);
    sh = 12'h000;
    repeat (8) @(posedge sys_clk);
    for (int i = 0; i < len; i++) begin
      sh[i] = line_from_dut;
      if (i < len - 1) repeat (16) @(posedge sys_clk);
    end
    got_q.push_back(sh);
  end
  // drive n bits lsb first, w cycles each, then idle high
  task automatic send(input logic [11:0] bits, input int n, input int w);
    for (int i = 0; i < n; i++) begin
      line_to_dut <= bits[i];
      repeat (w) @(posedge sys_clk);
    end
    line_to_dut <= 1'b1;
  endtask
endmodule

// file: tb.sv
// self-checking bench for the serial transceiver
`timescale 1ns/1ps
`include "uart_consts.vh"
module tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tx_line, rx_line, irq;
  logic [1:0] bresp, rresp, r, last_b;
  logic [31:0] rdata, d;
  int err_count = 0;
  int checks = 0;
  logic [7:0] modes [6] = '{8'h60, 8'h42, 8'h26, 8'h0A, 8'hE2, 8'hE6};
  always #2 sys_clk = ~sys_clk;
  uart_core #(.DEPTH(16), .AW(12)) dut_u (.sys_clk(sys_clk), .rst(rst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .serial_in_line(rx_line), .serial_out_line(tx_line),
    .irq(irq));
  serial_peer peer_u (.sys_clk(sys_clk), .line_from_dut(tx_line),
    .line_to_dut(rx_line));
  // verdict and end of run
  task automatic wrap_up;
    if (err_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // bus write: both channels offered together, each dropped when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    int n;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        last_b = bresp;
        break;
      end
    end
    bready <= 1'b0;
    if (n == 200) begin
      err_count++;
      wrap_up();
    end
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] v,
    output logic [1:0] rs);
    int n;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
    if (n == 200) begin
      err_count++;
      wrap_up();
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e, string nm);
    rd(a, d, r);
    chk(nm, d, e);
  endtask
  task automatic wait_rx(input int c);
    int n;
    for (n = 0; n < 4000 && peer_u.got_q.size() < c; n++)
      @(posedge sys_clk);
    if (n == 4000) begin
      err_count++;
      wrap_up();
    end
  endtask
  // disable, set line control, then apply the control word
  task automatic cfg(input logic [7:0] lc, input logic [9:0] ct);
    wr(`OFF_CTL, 32'h300);
    wr(`OFF_LCR, {24'h0, lc});
    wr(`OFF_CTL, {22'h0, ct});
  endtask
  // expected line bits of one frame, start bit first
  function automatic logic [11:0] frame(input logic [7:0] lc, dv);
    int w;
    logic [7:0] m;
    logic [11:0] f;
    w = 5 + lc[6:5];
    m = dv & (8'hFF >> (8 - w));
    f = 12'hFFF;
    f[0] = 1'b0;
    for (int i = 0; i < w; i++) f[i + 1] = m[i];
    if (lc[1]) f[w + 1] = lc[7] ? ~lc[2] : (lc[2] ? ^m : ~^m);
    return f & ((12'h1 << (2 + w + lc[1])) - 12'h1);
  endfunction
  task automatic tx_one(input logic [7:0] lc, dv);
    peer_u.len = 7 + lc[6:5] + lc[1];
    peer_u.got_q.delete();
    wr(`OFF_DATA, {24'h0, dv});
    rd(`OFF_FLAG, d, r);
    chk("busy", {31'h0, d[3]}, 32'h1);
    wait_rx(1);
    chk("frame", {20'h0, peer_u.got_q[0]}, {20'h0, frame(lc, dv)});
    repeat (40) @(posedge sys_clk);
    rd(`OFF_FLAG, d, r);
    chk("idle", {31'h0, d[3]}, 32'h0);
  endtask
  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    rdc(`OFF_CTL, 32'h300, "ctl");
    rdc(`OFF_FLS, 32'h12, "levels");
    rdc(`OFF_FLAG, 32'h90, "flags");
    rd(12'h100, d, r);
    chk("unmapped", {30'h0, r}, 32'h2);
    wr(12'h100, 32'h0);
    chk("wunmapped", {30'h0, last_b}, 32'h2);
    wr(`OFF_IDIV, 32'h1);
    wr(`OFF_FDIV, 32'h0);
    cfg(8'h60, 10'h301);
    wr(`OFF_IDIV, 32'h3);
    peer_u.len = 10;
    wr(`OFF_DATA, 32'h5A);
    wr(`OFF_DATA, 32'hC3);
    wait_rx(2);
    chk("b2b0", {20'h0, peer_u.got_q[0]}, {20'h0, frame(8'h60, 8'h5A)});
    chk("b2b1", {20'h0, peer_u.got_q[1]}, {20'h0, frame(8'h60, 8'hC3)});
    wr(`OFF_IDIV, 32'h1);
    foreach (modes[i]) begin
      cfg(modes[i], 10'h301);
      tx_one(modes[i], 8'hB4 ^ 8'(i));
    end
    cfg(8'h60, 10'h301);
    // disabling mid-character still lets the frame finish
    peer_u.len = 10;
    peer_u.got_q.delete();
    wr(`OFF_DATA, 32'h96);
    wr(`OFF_CTL, 32'h300);
    wait_rx(1);
    chk("finish", {20'h0, peer_u.got_q[0]}, {20'h0, frame(8'h60, 8'h96)});
    cfg(8'h60, 10'h301);
    peer_u.send({1'b1, 8'h3C, 1'b0}, 10, 16);
    rdc(`OFF_DATA, 32'h03C, "rx");
    peer_u.send(12'h000, 1, 4);
    repeat (40) @(posedge sys_clk);
    rdc(`OFF_FLAG, 32'h90, "glitch");
    peer_u.send({1'b0, 8'h81, 1'b0}, 10, 16);
    rdc(`OFF_DATA, 32'h181, "framing");
    peer_u.send(12'h000, 10, 16);
    rdc(`OFF_DATA, 32'h500, "break");
    cfg(8'h66, 10'h301);
    peer_u.send({2'b10, 8'h01, 1'b0}, 11, 16);
    rdc(`OFF_DATA, 32'h201, "parity");
    cfg(8'h60, 10'h301);
    wr(`OFF_RSR, 32'h0);
    peer_u.send({1'b1, 8'h11, 1'b0}, 10, 16);
    peer_u.send({1'b1, 8'h22, 1'b0}, 10, 16);
    rdc(`OFF_RSR, 32'h8, "overrun");
    rdc(`OFF_DATA, 32'h011, "kept");
    wr(`OFF_MASK, 32'h10);
    peer_u.send({1'b1, 8'h33, 1'b0}, 10, 16);
    repeat (4) @(posedge sys_clk);
    chk("irq", {31'h0, irq}, 32'h1);
    rdc(`OFF_DATA, 32'h833, "oe");
    repeat (4) @(posedge sys_clk);
    chk("irq off", {31'h0, irq}, 32'h0);
    wr(`OFF_MASK, 32'h0);
    cfg(8'h60, 10'h381);
    wr(`OFF_DATA, 32'h6E);
    repeat (200) @(posedge sys_clk);
    rdc(`OFF_DATA, 32'h06E, "loop");
    cfg(8'h70, 10'h300);
    for (int j = 0; j < 17; j++) wr(`OFF_DATA, j);
    rdc(`OFF_FLAG, 32'h38, "full");
    peer_u.len = 10;
    peer_u.got_q.delete();
    wr(`OFF_CTL, 32'h301);
    wait_rx(16);
    repeat (400) @(posedge sys_clk);
    chk("depth", peer_u.got_q.size(), 32'd16);
    chk("last", {20'h0, peer_u.got_q[15]}, {20'h0, frame(8'h70, 8'h0F)});
    wrap_up();
  end
endmodule
